/* logic/hbc_pkg.sv */
/*
 * hbc_pkg: shared types and constants of the h-bridge output control.
 * assumes a single 100 MHz clock and plain, synchronous pin inputs.
 */
`default_nettype none

package hbc_pkg;

    // one logic input pin: level plus "someone drives it"
    typedef struct packed {
        logic val;
        logic drv;
    } hbc_pin_s;

    // gate commands of one half-bridge; both low is tri-state
    typedef struct packed {
        logic hi;
        logic lo;
    } hbc_half_s;

    // analog detector results, already clean logic levels
    typedef struct packed {
        logic uv;
        logic oc;
        logic ot;
    } hbc_fault_s;

    typedef enum logic [0:0] {
        HBC_CHOP_RUN = 1'h0,
        HBC_CHOP_OFF = 1'h1
    } hbc_chop_e;

    // levels that the internal source/sink currents give a floating pin
    localparam logic HBC_DIS_DFLT = 1'h1;
    localparam logic HBC_EN_DFLT = 1'h0;
    localparam logic HBC_POL_DFLT = 1'h1;

    localparam hbc_half_s HBC_HALF_OFF = 2'h0;
    localparam hbc_half_s HBC_HALF_HI = 2'h2;
    localparam hbc_half_s HBC_HALF_LO = 2'h1;

    localparam int HBC_CLK_PERIOD_NS = 10;
    localparam int HBC_OFF_TIME_NS = 20000;
    // fixed off-time, rounded up to whole cycles
    localparam int HBC_OFF_CYC =
        (HBC_OFF_TIME_NS + HBC_CLK_PERIOD_NS - 1) / HBC_CLK_PERIOD_NS;
    localparam int HBC_CNT_W = 16;

endpackage

`default_nettype wire

/* logic/hbc_bridge_ctrl.sv */
/*
 * hbc_bridge_ctrl: control logic of an h-bridge motor driver.
 * resolves enable, disable and polarity pins into two half-bridge
 * gate commands, chops on over-current with a fixed off-time and
 * drives an open-drain fault flag.
 * assumes pins are synchronous to MCLK and that detector inputs
 * are clean levels from the analog side.
 */
// Functional notes
// - high disable input tri-states both half-bridge outputs, polarity ignored.
// - floating disable input counts as asserted, outputs tri-stated.
// - high enable input lets outputs follow polarity unless disabled; code also holds them off during under-voltage and off-time.
// - low enable input tri-states both outputs and enters sleep.
// - floating enable input counts as low, so device sleeps.
// - in normal operation output A high for polarity A high, else low.
// - in normal operation output B high for polarity B high, else low.
// - floating polarity A input counts as high, output A to supply.
// - floating polarity B input counts as high, output B to supply.
// - fault flag asserts on under-voltage, over-current or over-temperature.
// - fault flag is active-low open-drain; host supplies the pull-up.
// - over-current switches outputs off for fixed time, then re-enables, repeating.
`timescale 1ns/1ns
`default_nettype none

module hbc_bridge_ctrl
    import hbc_pkg::*;
#(
    parameter int OFF_CYC = HBC_OFF_CYC
) (
    input wire logic MCLK, // 100 MHz clock
    input wire logic RST_N, // sync reset, active low
    input wire hbc_pin_s DISABLE_INPUT, // disable pin, active high
    input wire hbc_pin_s BRIDGE_ENABLE_INPUT, // enable / sleep pin
    input wire hbc_pin_s POLARITY_IN_A, // polarity of half A
    input wire hbc_pin_s POLARITY_IN_B, // polarity of half B
    input wire hbc_fault_s FAULT_DET, // detector levels
    input wire logic FAULT_FLAG_N_LVL, // flag wire level
    output hbc_half_s HALF_BRIDGE_OUT_A, // gates of half A
    output hbc_half_s HALF_BRIDGE_OUT_B, // gates of half B
    output logic SLEEP_ACT, // sleep condition
    output logic CHOP_ACT, // off-time running
    output logic FAULT_FLAG_N_VAL, // flag drive value
    output logic FAULT_FLAG_N_OE_N, // low while pulling flag
    output logic FLAG_LINE_LOW // flag wire seen low
);

    // resolved pin levels
    logic dis_res;
    logic en_res;
    logic pol_a_res;
    logic pol_b_res;
    logic bridge_off;

    always_comb begin
        dis_res = DISABLE_INPUT.drv ? DISABLE_INPUT.val : HBC_DIS_DFLT;
        en_res = BRIDGE_ENABLE_INPUT.drv ? BRIDGE_ENABLE_INPUT.val
                                         : HBC_EN_DFLT;
        pol_a_res = POLARITY_IN_A.drv ? POLARITY_IN_A.val : HBC_POL_DFLT;
        pol_b_res = POLARITY_IN_B.drv ? POLARITY_IN_B.val : HBC_POL_DFLT;
        // under-voltage also locks the bridge off; gates are unsafe then
        bridge_off = !en_res || dis_res || FAULT_DET.uv;
    end

    // over-current chopper
    hbc_chop_e chop_reg;
    hbc_chop_e chop_next;
    logic [HBC_CNT_W-1:0] off_cnt_reg;
    logic [HBC_CNT_W-1:0] off_cnt_next;

    always_comb begin
        chop_next = chop_reg;
        off_cnt_next = off_cnt_reg;
        case (chop_reg)
            HBC_CHOP_RUN: begin
                // only a driven bridge can carry load current
                if (FAULT_DET.oc && !bridge_off) begin
                    chop_next = HBC_CHOP_OFF;
                    off_cnt_next = HBC_CNT_W'(OFF_CYC - 1);
                end
            end
            HBC_CHOP_OFF: begin
                if (off_cnt_reg == '0) begin
                    chop_next = HBC_CHOP_RUN;
                end else begin
                    off_cnt_next = off_cnt_reg - 1'h1;
                end
            end
            default: begin
                chop_next = HBC_CHOP_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            chop_reg <= HBC_CHOP_RUN;
            off_cnt_reg <= '0;
        end else begin
            chop_reg <= chop_next;
            off_cnt_reg <= off_cnt_next;
        end
    end

    // output resolution
    hbc_half_s out_a_next;
    hbc_half_s out_b_next;
    logic sleep_next;
    logic norm_op;

    always_comb begin
        sleep_next = !en_res;
        norm_op = !bridge_off && (chop_next == HBC_CHOP_RUN);
        // sleep first, then disable, then under-voltage or off-time, then polarity
        if (!en_res) begin
            out_a_next = HBC_HALF_OFF;
            out_b_next = HBC_HALF_OFF;
        end else if (dis_res) begin
            out_a_next = HBC_HALF_OFF;
            out_b_next = HBC_HALF_OFF;
        end else if (!norm_op) begin
            out_a_next = HBC_HALF_OFF;
            out_b_next = HBC_HALF_OFF;
        end else begin
            out_a_next = pol_a_res ? HBC_HALF_HI : HBC_HALF_LO;
            out_b_next = pol_b_res ? HBC_HALF_HI : HBC_HALF_LO;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            HALF_BRIDGE_OUT_A <= HBC_HALF_OFF;
            HALF_BRIDGE_OUT_B <= HBC_HALF_OFF;
            SLEEP_ACT <= 1'h1;
            CHOP_ACT <= 1'h0;
        end else begin
            HALF_BRIDGE_OUT_A <= out_a_next;
            HALF_BRIDGE_OUT_B <= out_b_next;
            SLEEP_ACT <= sleep_next;
            CHOP_ACT <= (chop_next == HBC_CHOP_OFF);
        end
    end

    // fault flag, open drain: value fixed low, enable does the work
    logic flag_oe_n_next;
    logic line_low_next;

    always_comb begin
        flag_oe_n_next = !(FAULT_DET.uv || FAULT_DET.oc || FAULT_DET.ot);
        // wire may be shared, so report what it really shows
        line_low_next = !FAULT_FLAG_N_LVL;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            FAULT_FLAG_N_VAL <= 1'h0;
            FAULT_FLAG_N_OE_N <= 1'h1;
            FLAG_LINE_LOW <= 1'h0;
        end else begin
            FAULT_FLAG_N_VAL <= 1'h0;
            FAULT_FLAG_N_OE_N <= flag_oe_n_next;
            FLAG_LINE_LOW <= line_low_next;
        end
    end

    // checks

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    // helper: length of each off-time as seen on CHOP_ACT
    logic [HBC_CNT_W-1:0] held_reg;
    logic [HBC_CNT_W-1:0] held_next;

    always_comb begin
        held_next = CHOP_ACT ? held_reg + 1'h1 : '0;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            held_reg <= '0;
        end else begin
            held_reg <= held_next;
        end
    end

    sequence s_chop_enter;
        !CHOP_ACT ##1 CHOP_ACT;
    endsequence

    sequence s_chop_leave;
        CHOP_ACT ##1 !CHOP_ACT;
    endsequence

    a_dis_tristate: assert property (
        (en_res && dis_res) |=>
            (HALF_BRIDGE_OUT_A == HBC_HALF_OFF) &&
            (HALF_BRIDGE_OUT_B == HBC_HALF_OFF))
        else $error("disable did not tri-state the bridge");

    a_dis_float: assert property (
        !DISABLE_INPUT.drv |=>
            (HALF_BRIDGE_OUT_A == HBC_HALF_OFF) &&
            (HALF_BRIDGE_OUT_B == HBC_HALF_OFF))
        else $error("floating disable left the bridge driven");

    a_run_driven: assert property (
        norm_op |=> !SLEEP_ACT &&
            (HALF_BRIDGE_OUT_A != HBC_HALF_OFF) &&
            (HALF_BRIDGE_OUT_B != HBC_HALF_OFF))
        else $error("enabled bridge not driven");

    a_sleep_exit: assert property (
        en_res |=> !SLEEP_ACT)
        else $error("high enable stayed asleep");

    a_sleep_off: assert property (
        !en_res |=> SLEEP_ACT &&
            (HALF_BRIDGE_OUT_A == HBC_HALF_OFF) &&
            (HALF_BRIDGE_OUT_B == HBC_HALF_OFF))
        else $error("low enable did not sleep");

    a_en_float: assert property (
        !BRIDGE_ENABLE_INPUT.drv |=> SLEEP_ACT)
        else $error("floating enable did not sleep");

    a_follow_a: assert property (
        norm_op |=> HALF_BRIDGE_OUT_A ==
            ($past(pol_a_res) ? HBC_HALF_HI : HBC_HALF_LO))
        else $error("half A does not follow polarity");

    a_follow_b: assert property (
        norm_op |=> HALF_BRIDGE_OUT_B ==
            ($past(pol_b_res) ? HBC_HALF_HI : HBC_HALF_LO))
        else $error("half B does not follow polarity");

    a_float_pol_a: assert property (
        (norm_op && !POLARITY_IN_A.drv) |=> HALF_BRIDGE_OUT_A == HBC_HALF_HI)
        else $error("floating polarity A not high");

    a_float_pol_b: assert property (
        (norm_op && !POLARITY_IN_B.drv) |=> HALF_BRIDGE_OUT_B == HBC_HALF_HI)
        else $error("floating polarity B not high");

    a_flag_fault: assert property (
        (FAULT_DET.uv || FAULT_DET.oc || FAULT_DET.ot) |=> !FAULT_FLAG_N_OE_N)
        else $error("fault not flagged");

    a_flag_release: assert property (
        !(FAULT_DET.uv || FAULT_DET.oc || FAULT_DET.ot) |=> FAULT_FLAG_N_OE_N)
        else $error("flag held without fault");

    a_flag_odrain: assert property (
        !FAULT_FLAG_N_OE_N |-> !FAULT_FLAG_N_VAL)
        else $error("flag driven high");

    a_line_seen: assert property (
        !FAULT_FLAG_N_LVL |=> FLAG_LINE_LOW)
        else $error("low flag wire not reported");

    a_chop_trip: assert property (
        (FAULT_DET.oc && !bridge_off && !CHOP_ACT) |=> CHOP_ACT)
        else $error("over-current did not start off-time");

    a_chop_off_out: assert property (
        CHOP_ACT |-> (HALF_BRIDGE_OUT_A == HBC_HALF_OFF) &&
            (HALF_BRIDGE_OUT_B == HBC_HALF_OFF))
        else $error("bridge driven during off-time");

    a_chop_length: assert property (
        s_chop_leave |-> held_reg == HBC_CNT_W'(OFF_CYC))
        else $error("off-time has wrong length");

    // off-time may exceed any delay range, so the counter bounds it
    a_chop_ends: assert property (
        CHOP_ACT |-> held_reg < HBC_CNT_W'(OFF_CYC))
        else $error("off-time never ended");

    a_chop_cause: assert property (
        s_chop_enter |-> $past(FAULT_DET.oc) && !$past(bridge_off))
        else $error("off-time started without over-current");

    a_chop_ignored: assert property (
        (FAULT_DET.oc && bridge_off && !CHOP_ACT) |=> !CHOP_ACT)
        else $error("over-current chopped an idle bridge");

    a_prio_sleep: assert property (
        (!en_res && !dis_res) |=> SLEEP_ACT &&
            (HALF_BRIDGE_OUT_A == HBC_HALF_OFF))
        else $error("sleep lost priority");

    a_prio_dis: assert property (
        (en_res && dis_res) |=> !SLEEP_ACT)
        else $error("disable entered sleep");

endmodule // hbc_bridge_ctrl

`default_nettype wire

/* verif/hbc_host_model.sv */
/*
 * hbc_host_model: host side of the bridge control, the pull-up on the
 * open-drain fault flag wire and the host's reading of that wire.
 * assumes the device drives the flag value and its active-low enable.
 */
`timescale 1ns/1ns
`default_nettype none

module hbc_host_model (
    input wire logic flag_val, // device flag drive value
    input wire logic flag_oe_n, // low while device pulls
    output logic flag_wire, // resolved wire level
    output logic fault_seen // host reads a fault
);
    // released wire goes to the pull-up level, never the last value
    assign flag_wire = flag_oe_n ? 1'h1 : flag_val;
    assign fault_seen = !flag_wire;
endmodule // hbc_host_model

`default_nettype wire

/* verif/hbc_bridge_ctrl_tb.sv */
/*
 * hbc_bridge_ctrl_tb: self-checking bench of the bridge control.
 * assumes the host model resolves the flag wire; off-time shortened.
 */
`timescale 1ns/1ns
`default_nettype none

module hbc_bridge_ctrl_tb
    import hbc_pkg::*;
;
    localparam int OFFC = 4;
    // half period of the fastest polarity modulation the host may use
    localparam int PWM_HALF_CYC = 4546;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    hbc_pin_s en = 2'h0, dis = 2'h0, pa = 2'h0, pb = 2'h0;
    hbc_fault_s det = 3'h0;
    hbc_half_s out_a, out_b;
    logic sleep_act, chop_act, flag_val, flag_oe_n, flag_low, flag_wire, fault_seen;
    int fails = 0, comparisons = 0, cycles = 0;

    always #5 mclk = ~mclk;

    hbc_bridge_ctrl #(.OFF_CYC(OFFC)) dut (
        .MCLK(mclk), .RST_N(rst_n), .DISABLE_INPUT(dis), .BRIDGE_ENABLE_INPUT(en),
        .POLARITY_IN_A(pa), .POLARITY_IN_B(pb), .FAULT_DET(det),
        .FAULT_FLAG_N_LVL(flag_wire), .HALF_BRIDGE_OUT_A(out_a), .HALF_BRIDGE_OUT_B(out_b),
        .SLEEP_ACT(sleep_act), .CHOP_ACT(chop_act), .FAULT_FLAG_N_VAL(flag_val),
        .FAULT_FLAG_N_OE_N(flag_oe_n), .FLAG_LINE_LOW(flag_low)
    );

    hbc_host_model host (
        .flag_val(flag_val), .flag_oe_n(flag_oe_n), .flag_wire(flag_wire),
        .fault_seen(fault_seen)
    );

    task automatic conclude();
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        // reset, pin sweep and chopping are short; one modulation period dominates
        if (cycles == 12000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick();
        @(negedge mclk);
    endtask

    // expected half-bridge command from resolved enable, disable, polarity
    function automatic hbc_half_s half_exp(input logic en_r, input logic dis_r,
                                           input hbc_pin_s p);
        if (!en_r || dis_r) begin
            return HBC_HALF_OFF;
        end
        return (p.drv ? p.val : 1'h1) ? HBC_HALF_HI : HBC_HALF_LO;
    endfunction

    task automatic test_reset();
        rst_n = 1'h0;
        repeat (12) tick();
        chk("rst_out_a", HBC_HALF_OFF, out_a);
        chk("rst_sleep", 2'h1, {1'h0, sleep_act});
        chk("rst_flag", 2'h1, {1'h0, flag_wire});
        chk("rst_line_low", 2'h0, {1'h0, flag_low});
        rst_n = 1'h1;
    endtask

    // every level and floating combination of the four pins
    task automatic test_pins();
        hbc_pin_s e, d, p, q;
        logic en_r, dis_r;
        for (int i = 0; i < 256; i++) begin
            e = i[7:6];
            d = i[5:4];
            p = i[3:2];
            q = i[1:0];
            en = e;
            dis = d;
            pa = p;
            pb = q;
            tick();
            en_r = e.drv ? e.val : 1'h0;
            dis_r = d.drv ? d.val : 1'h1;
            chk("sleep", {1'h0, !en_r}, {1'h0, sleep_act});
            chk("out_a", half_exp(en_r, dis_r, p), out_a);
            chk("out_b", half_exp(en_r, dis_r, q), out_b);
        end
    endtask

    task automatic test_chop();
        en = 2'h3;
        dis = 2'h3;
        pa = 2'h3;
        pb = 2'h1;
        det = 3'h2;
        // over-current on a disabled bridge must not start an off-time
        tick();
        chk("chop_idle", 2'h0, {1'h0, chop_act});
        dis = 2'h1;
        for (int k = 1; k <= OFFC + 2; k++) begin
            tick();
            chk("chop", {1'h0, k != OFFC + 1}, {1'h0, chop_act});
            chk("chop_a", (k == OFFC + 1) ? HBC_HALF_HI : HBC_HALF_OFF, out_a);
            chk("chop_b", (k == OFFC + 1) ? HBC_HALF_LO : HBC_HALF_OFF, out_b);
            chk("oc_flag", 2'h0, {1'h0, flag_wire});
        end
        det = 3'h0;
        repeat (OFFC + 2) tick();
        chk("oc_clear", 2'h1, {1'h0, flag_wire});
    endtask

    // under-voltage then over-temperature; flag is not latched
    task automatic test_flag();
        en = 2'h3;
        dis = 2'h1;
        pa = 2'h1;
        pb = 2'h3;
        for (int j = 0; j < 2; j++) begin
            det = j ? 3'h1 : 3'h4;
            tick();
            chk("oe_n", 2'h0, {1'h0, flag_oe_n});
            chk("seen", 2'h1, {1'h0, fault_seen});
            tick();
            chk("line_low", 2'h1, {1'h0, flag_low});
            chk("fault_b", j ? HBC_HALF_HI : HBC_HALF_OFF, out_b);
            det = 3'h0;
            tick();
            chk("oe_n_clr", 2'h1, {1'h0, flag_oe_n});
            tick();
        end
    endtask

    // one full period of polarity modulation at the highest allowed rate
    task automatic test_pwm();
        en = 2'h3;
        dis = 2'h1;
        pb = 2'h3;
        det = 3'h0;
        for (int h = 0; h < 2; h++) begin
            pa = h ? 2'h1 : 2'h3;
            repeat (PWM_HALF_CYC) tick();
            chk("pwm_a", h ? HBC_HALF_LO : HBC_HALF_HI, out_a);
            chk("pwm_chop", 2'h0, {1'h0, chop_act});
        end
    endtask

    initial begin
        test_reset();
        test_pins();
        test_chop();
        test_flag();
        test_pwm();
        test_reset();
        conclude();
    end
endmodule // hbc_bridge_ctrl_tb

`default_nettype wire
